// file: hdl/mon_consts.svh
`ifndef MON_CONSTS_SVH
`define MON_CONSTS_SVH

// ==========================================================================
// Register offsets
`define OFS_CONFIG     8'h00
`define OFS_SHUNT_RES  8'h01
`define OFS_BUS_RES    8'h02
`define OFS_POWER_RES  8'h03
`define OFS_MASK       8'h06
`define OFS_LIMIT      8'h07

// ==========================================================================
// Reset values
`define CONFIG_RESET   16'h0127
`define MASK_RESET     16'h0000
`define LIMIT_RESET    16'h0000

// ==========================================================================
// Mask/enable field positions
`define ME_SHUNT_OVER  15
`define ME_SHUNT_UNDER 14
`define ME_BUS_OVER    13
`define ME_BUS_UNDER   12
`define ME_POWER_OVER  11
`define ME_READY_EN    10
`define ME_VIOL_FLAG   4
`define ME_READY_FLAG  3
`define ME_LEVEL_SEL   1
`define ME_LATCH_EN    0
`define ME_WR_MASK     16'hfc03

// ==========================================================================
// Operating modes
`define MODE_SINGLE    3'h1
`define MODE_CONT      3'h7

// ==========================================================================
// Timing, in microseconds
`define RECOVER_US     14'h0064
`define CT0_US         14'h008c
`define CT1_US         14'h00cc
`define CT2_US         14'h014c
`define CT3_US         14'h024c
`define CT4_US         14'h044c
`define CT5_US         14'h0844
`define CT6_US         14'h103c
`define CT7_US         14'h2034

`endif

// file: hdl/mon_pkg.sv
package mon_pkg;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic       rst;
    logic [2:0] rsvd;
    logic [2:0] avg;
    logic [2:0] bus_ct;
    logic [2:0] shunt_ct;
    logic [2:0] mode;
  } cfg_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] shunt;
    logic [15:0] bus;
    logic [15:0] power;
  } sample_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_SHUNT_OVER,
    SEL_SHUNT_UNDER,
    SEL_BUS_OVER,
    SEL_BUS_UNDER,
    SEL_POWER_OVER
  } check_sel_t;

endpackage : mon_pkg

// file: hdl/conv_timer.sv
`timescale 1ns/1ps
module conv_timer #(
  parameter int CYCLES_PER_US = 100
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_start,
  input  wire logic [13:0] i_us,
  output logic             o_done
);

  logic [15:0] div_q;
  logic [13:0] us_q;
  logic        run_q;
  wire         tick = (div_q == 16'(CYCLES_PER_US - 1));

  // ========================================================================
  // Microsecond enable, then down count; restart discards a running count
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_start) begin
      div_q <= 16'h0000;
    end else if (tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      us_q   <= 14'h0000;
      run_q  <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        us_q  <= i_us;
        run_q <= 1'b1;
      end else if (run_q && tick) begin
        if (us_q <= 14'h0001) begin
          run_q  <= 1'b0;
          o_done <= 1'b1;
        end
        us_q <= us_q - 14'h0001;
      end
    end
  end

endmodule : conv_timer

// file: hdl/mon_ctrl.sv
`timescale 1ns/1ps
`include "mon_consts.svh"
// Overview of operation
// - Five limit checks, each enabled by its own mask bit.
// - Highest enabled check bit wins; lower ones ignored.
// - Alert asserts when active check violates the threshold register.
// - Shunt checks compare after every single shunt conversion.
// - Bus checks compare after every bus conversion, setting flag and alert.
// - Power check compares new power after every bus conversion.
// - Checks use single samples, never the averaged result.
// - Violation flag bit D4 goes high when the active check is violated.
// - Alert active level follows the level select bit D1.
// - Latched flag and alert clear on config write or mask read.
// - Ready enable also signals completion; software reads D3 and D4.
// - Ready enable clear: alert reflects limit violations only.
// - Mode 111 repeats shunt then bus conversions continuously.
// - Mode 001 write starts one set; rewrite needed for each further.
// - Ready flag sets once all samples and averaging finish.
// - Ready clears on non-power-down config write or mask read.
// - Power-down stops conversions; 100 us recovery when leaving.
// - Reset returns all registers to defaults; reset bit D15 leaves the result registers holding their values.
// - Separate shunt and bus conversion times plus averaging count.
// - Result registers readable anytime, hold last completed cycle.
// - Samples accumulate; averages load to results only at the end.
module mon_ctrl
  import mon_pkg::*;
#(
  parameter int CYCLES_PER_US = 100
) (
  input  wire logic              I_REF_CLK,
  input  wire logic              I_RST_N,
  input  wire mon_pkg::reg_req_t I_REG_REQ,
  input  wire mon_pkg::sample_t  I_SAMPLE,
  output mon_pkg::sample_t       O_RESULT,
  output logic [15:0]            O_REG_RDATA,
  output logic                   O_SHUNT_CONV,
  output logic                   O_BUS_CONV,
  output logic                   O_ALERT_O,
  output logic                   O_ALERT_OE
);
  import mon_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_RECOVER, ST_SHUNT, ST_BUS} state_t;

  // ========================================================================
  // Lookups
  function automatic logic [13:0] ct_us(input logic [2:0] code);
    case (code)
      3'h0:    ct_us = `CT0_US;
      3'h1:    ct_us = `CT1_US;
      3'h2:    ct_us = `CT2_US;
      3'h3:    ct_us = `CT3_US;
      3'h4:    ct_us = `CT4_US;
      3'h5:    ct_us = `CT5_US;
      3'h6:    ct_us = `CT6_US;
      default: ct_us = `CT7_US;
    endcase
  endfunction : ct_us

  // Averaging counts are powers of two, so division is a shift
  function automatic logic [3:0] avg_shift(input logic [2:0] code);
    case (code)
      3'h0:    avg_shift = 4'h0;
      3'h1:    avg_shift = 4'h2;
      3'h2:    avg_shift = 4'h4;
      3'h3:    avg_shift = 4'h6;
      3'h4:    avg_shift = 4'h7;
      3'h5:    avg_shift = 4'h8;
      3'h6:    avg_shift = 4'h9;
      default: avg_shift = 4'ha;
    endcase
  endfunction : avg_shift

  function automatic logic mode_active(input logic [2:0] m);
    mode_active = (m == `MODE_CONT) || (m == `MODE_SINGLE);
  endfunction : mode_active

  // ========================================================================
  // Registers
  cfg_t        cfg_q;
  logic [15:0] me_q;
  logic [15:0] limit_q;
  logic        aff_q;
  logic        conversion_ready_flag_q;
  logic        pd_q;
  logic        kick_q;
  state_t      state_q;
  state_t      state_d;
  logic [10:0] cnt_q;
  logic [26:0] acc_sh_q;
  logic [26:0] acc_bus_q;
  logic [26:0] acc_pw_q;

  // ========================================================================
  // Register access decode
  wire   cfg_wr  = I_REG_REQ.wr && (I_REG_REQ.addr == `OFS_CONFIG);
  wire   me_wr   = I_REG_REQ.wr && (I_REG_REQ.addr == `OFS_MASK);
  wire   lim_wr  = I_REG_REQ.wr && (I_REG_REQ.addr == `OFS_LIMIT);
  wire   me_rd   = I_REG_REQ.rd && (I_REG_REQ.addr == `OFS_MASK);
  wire   soft_rst = cfg_wr && I_REG_REQ.wdata[15];
  cfg_t  cfg_new;
  assign cfg_new = soft_rst ? cfg_t'(`CONFIG_RESET)
                            : cfg_t'(I_REG_REQ.wdata & 16'h0fff);
  wire   new_act = mode_active(cfg_new.mode);

  // ========================================================================
  // Active check selection, highest enabled bit first
  check_sel_t sel;
  assign sel = me_q[`ME_SHUNT_OVER]  ? SEL_SHUNT_OVER  :
               me_q[`ME_SHUNT_UNDER] ? SEL_SHUNT_UNDER :
               me_q[`ME_BUS_OVER]    ? SEL_BUS_OVER    :
               me_q[`ME_BUS_UNDER]   ? SEL_BUS_UNDER   :
               me_q[`ME_POWER_OVER]  ? SEL_POWER_OVER  : SEL_NONE;

  // ========================================================================
  // Conversion timer
  logic        tmr_start;
  logic [13:0] tmr_us;
  logic        tmr_done;

  conv_timer #(
    .CYCLES_PER_US (CYCLES_PER_US)
  ) u_timer (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .i_start (tmr_start),
    .i_us    (tmr_us),
    .o_done  (tmr_done)
  );

  // ========================================================================
  // Sample handling: sums for averaging, checks on single results
  wire sh_done  = (state_q == ST_SHUNT) && tmr_done;
  wire bus_done = (state_q == ST_BUS) && tmr_done;
  wire [26:0] sh_sum  = acc_sh_q + 27'(signed'(I_SAMPLE.shunt));
  wire [26:0] bus_sum = acc_bus_q + 27'(I_SAMPLE.bus);
  wire [26:0] pw_sum  = acc_pw_q + 27'(I_SAMPLE.power);
  wire [3:0]  shift   = avg_shift(cfg_q.avg);
  wire        last    = bus_done && (cnt_q == ~(11'h7ff << shift));

  wire sh_over  = signed'(I_SAMPLE.shunt) > signed'(limit_q);
  wire sh_under = signed'(I_SAMPLE.shunt) < signed'(limit_q);
  wire bus_over = I_SAMPLE.bus > limit_q;
  wire bus_undr = I_SAMPLE.bus < limit_q;
  wire pw_over  = I_SAMPLE.power > limit_q;

  // Shunt checks after each shunt sample, bus and power after each bus one
  wire chk_ev = (sh_done && (sel == SEL_SHUNT_OVER
                          || sel == SEL_SHUNT_UNDER))
             || (bus_done && (sel == SEL_BUS_OVER
                          || sel == SEL_BUS_UNDER
                          || sel == SEL_POWER_OVER));
  wire viol = (sel == SEL_SHUNT_OVER  && sh_over)
           || (sel == SEL_SHUNT_UNDER && sh_under)
           || (sel == SEL_BUS_OVER    && bus_over)
           || (sel == SEL_BUS_UNDER   && bus_undr)
           || (sel == SEL_POWER_OVER  && pw_over);

  // ========================================================================
  // Sequencer
  always_comb begin
    state_d   = state_q;
    tmr_start = 1'b0;
    tmr_us    = ct_us(cfg_q.shunt_ct);
    if (cfg_wr) begin
      if (!new_act) begin
        state_d = ST_IDLE;
      end else if (pd_q) begin
        state_d   = ST_RECOVER;
        tmr_start = 1'b1;
        tmr_us    = `RECOVER_US;
      end else begin
        state_d   = ST_SHUNT;
        tmr_start = 1'b1;
        tmr_us    = ct_us(cfg_new.shunt_ct);
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (kick_q && mode_active(cfg_q.mode)) begin
            state_d   = ST_SHUNT;
            tmr_start = 1'b1;
          end
        end
        ST_RECOVER: begin
          if (tmr_done) begin
            state_d   = ST_SHUNT;
            tmr_start = 1'b1;
          end
        end
        ST_SHUNT: begin
          if (tmr_done) begin
            state_d   = ST_BUS;
            tmr_start = 1'b1;
            tmr_us    = ct_us(cfg_q.bus_ct);
          end
        end
        ST_BUS: begin
          if (tmr_done) begin
            if (!last || cfg_q.mode == `MODE_CONT) begin
              state_d   = ST_SHUNT;
              tmr_start = 1'b1;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      state_q <= ST_IDLE;
      kick_q  <= 1'b1;
      pd_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      kick_q  <= 1'b0;
      if (cfg_wr && !new_act) begin
        pd_q <= 1'b1;
      end else if (state_q == ST_RECOVER && tmr_done) begin
        pd_q <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Accumulators and result registers
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N || cfg_wr) begin
      cnt_q     <= 11'h000;
      acc_sh_q  <= 27'h0000000;
      acc_bus_q <= 27'h0000000;
      acc_pw_q  <= 27'h0000000;
    end else if (last) begin
      cnt_q     <= 11'h000;
      acc_sh_q  <= 27'h0000000;
      acc_bus_q <= 27'h0000000;
      acc_pw_q  <= 27'h0000000;
    end else begin
      if (sh_done) begin
        acc_sh_q <= sh_sum;
      end
      if (bus_done) begin
        acc_bus_q <= bus_sum;
        acc_pw_q  <= pw_sum;
        cnt_q     <= cnt_q + 11'h001;
      end
    end
  end

  // Only a complete set updates the results
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_RESULT <= '0;
    end else if (last) begin
      O_RESULT.shunt <= 16'(signed'(acc_sh_q) >>> shift);
      O_RESULT.bus   <= 16'(bus_sum >> shift);
      O_RESULT.power <= 16'(pw_sum >> shift);
    end
  end

  // ========================================================================
  // Control registers
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N || soft_rst) begin
      cfg_q   <= cfg_t'(`CONFIG_RESET);
      me_q    <= `MASK_RESET;
      limit_q <= `LIMIT_RESET;
    end else begin
      if (cfg_wr) begin
        cfg_q <= cfg_new;
      end
      if (me_wr) begin
        me_q <= I_REG_REQ.wdata & `ME_WR_MASK;
      end
      if (lim_wr) begin
        limit_q <= I_REG_REQ.wdata;
      end
    end
  end

  // ========================================================================
  // Flags; a set in the clearing cycle wins
  wire rdy_clr = (cfg_wr && new_act) || me_rd;
  wire aff_clr = cfg_wr || me_rd;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      conversion_ready_flag_q <= 1'b0;
      aff_q  <= 1'b0;
    end else begin
      if (last) begin
        conversion_ready_flag_q <= 1'b1;
      end else if (rdy_clr) begin
        conversion_ready_flag_q <= 1'b0;
      end
      if (chk_ev && viol) begin
        aff_q <= 1'b1;
      end else if (chk_ev && !me_q[`ME_LATCH_EN]) begin
        aff_q <= 1'b0;
      end else if (aff_clr) begin
        aff_q <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Alert pin, open drain: pulls low while driving
  wire alert_act = aff_q
                || (me_q[`ME_READY_EN] && conversion_ready_flag_q);
  assign O_ALERT_O  = 1'b0;
  assign O_ALERT_OE = me_q[`ME_LEVEL_SEL] ? !alert_act : alert_act;

  assign O_SHUNT_CONV = (state_q == ST_SHUNT);
  assign O_BUS_CONV   = (state_q == ST_BUS);

  // ========================================================================
  // Read data
  wire [15:0] me_rd_val = {me_q[15:10], 5'h00, aff_q, conversion_ready_flag_q,
                           1'b0, me_q[`ME_LEVEL_SEL], me_q[`ME_LATCH_EN]};
  wire [15:0] rd_mux =
    (I_REG_REQ.addr == `OFS_CONFIG)    ? 16'(cfg_q)    :
    (I_REG_REQ.addr == `OFS_SHUNT_RES) ? O_RESULT.shunt :
    (I_REG_REQ.addr == `OFS_BUS_RES)   ? O_RESULT.bus   :
    (I_REG_REQ.addr == `OFS_POWER_RES) ? O_RESULT.power :
    (I_REG_REQ.addr == `OFS_MASK)      ? me_rd_val      :
    (I_REG_REQ.addr == `OFS_LIMIT)     ? limit_q        : 16'h0000;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_REG_RDATA <= 16'h0000;
    end else if (I_REG_REQ.rd) begin
      O_REG_RDATA <= rd_mux;
    end
  end

endmodule : mon_ctrl

// file: verification/mon_checker.sv
`timescale 1ns/1ps
module mon_checker #(
  parameter int CYCLES_PER_US = 100
) (
  input  wire logic              I_REF_CLK,
  input  wire logic              I_RST_N,
  input  wire mon_pkg::reg_req_t I_REG_REQ,
  input  wire mon_pkg::sample_t  I_SAMPLE,
  input  wire mon_pkg::sample_t  O_RESULT,
  input  wire logic [15:0]       O_REG_RDATA,
  input  wire logic              O_SHUNT_CONV,
  input  wire logic              O_BUS_CONV,
  input  wire logic              O_ALERT_O,
  input  wire logic              O_ALERT_OE
);
  import mon_pkg::*;
  // ========================================================================
  // Shadow registers
  logic [15:0] cfg_q;
  logic [15:0] mask_q;
  logic [15:0] lim_q;
  logic [15:0] rec_q;
  wire  wr_cfg = I_REG_REQ.wr && I_REG_REQ.addr == 8'h00;
  wire  pd_now = cfg_q[2:0] != 3'h1 && cfg_q[2:0] != 3'h7;
  wire  go_act = I_REG_REQ.wdata[2:0] == 3'h1 || I_REG_REQ.wdata[2:0] == 3'h7;
  wire  viol   = $signed(I_SAMPLE.shunt) > $signed(lim_q);
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      cfg_q  <= 16'h0127;
      mask_q <= 16'h0000;
      lim_q  <= 16'h0000;
      rec_q  <= 16'h0000;
    end else begin
      // Soft reset is not modelled; the bench never sets it
      if (wr_cfg) cfg_q <= I_REG_REQ.wdata & 16'h0fff;
      if (I_REG_REQ.wr && I_REG_REQ.addr == 8'h06) mask_q <= I_REG_REQ.wdata;
      if (I_REG_REQ.wr && I_REG_REQ.addr == 8'h07) lim_q <= I_REG_REQ.wdata;
      // Slack of a few cycles covers the timer's start-up jitter
      if (wr_cfg && go_act && pd_now) rec_q <= 16'(100 * CYCLES_PER_US - 4);
      else if (rec_q != 16'h0000) rec_q <= rec_q - 16'h0001;
    end
  end
  // ========================================================================
  // Properties
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_N);
  sequence s_pd_write;
    wr_cfg && !go_act;
  endsequence
  sequence s_shunt_end;
    $fell(O_SHUNT_CONV) && !$past(wr_cfg);
  endsequence
  sequence s_bus_end;
    $fell(O_BUS_CONV) && !$past(wr_cfg);
  endsequence
  chk_conv_exclusive: assert property (!(O_SHUNT_CONV && O_BUS_CONV))
    else $error("shunt and bus conversions overlap");
  chk_shunt_then_bus: assert property (
    s_shunt_end |-> ##[0:2] O_BUS_CONV)
    else $error("bus conversion did not follow shunt");
  chk_cont_repeat: assert property (
    s_bus_end and cfg_q[2:0] == 3'h7 |-> ##[0:3] O_SHUNT_CONV)
    else $error("continuous mode did not restart");
  chk_single_stop: assert property (
    s_bus_end and cfg_q[2:0] == 3'h1 && cfg_q[11:9] == 3'h0
    |=> (!O_SHUNT_CONV)[*8])
    else $error("single shot converted again");
  chk_pd_quiet: assert property (
    s_pd_write |=> (!O_SHUNT_CONV && !O_BUS_CONV)[*8])
    else $error("conversion during power-down");
  chk_wake_delay: assert property ($rose(O_SHUNT_CONV) |-> rec_q == 0)
    else $error("conversion before recovery time");
  chk_limit_read: assert property (
    I_REG_REQ.rd && !I_REG_REQ.wr && I_REG_REQ.addr == 8'h07
    |=> O_REG_RDATA == lim_q)
    else $error("threshold read mismatch");
  chk_shunt_alert: assert property (
    s_shunt_end and mask_q[15:10] == 6'b100000 && !mask_q[0]
    |-> ##[0:2] O_ALERT_OE == ($past(viol) ^ mask_q[1]))
    else $error("alert does not follow shunt check");
  chk_alert_data: assert property (O_ALERT_O == 1'b0)
    else $error("open drain data not low");
endmodule : mon_checker

bind mon_ctrl mon_checker #(.CYCLES_PER_US(CYCLES_PER_US)) i_mon_checker (
  .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_REG_REQ(I_REG_REQ),
  .I_SAMPLE(I_SAMPLE), .O_RESULT(O_RESULT), .O_REG_RDATA(O_REG_RDATA),
  .O_SHUNT_CONV(O_SHUNT_CONV), .O_BUS_CONV(O_BUS_CONV),
  .O_ALERT_O(O_ALERT_O), .O_ALERT_OE(O_ALERT_OE));

// file: verification/front_end_model.sv
`timescale 1ns/1ps
module front_end_model (
  input  wire logic             i_shunt_conv,
  input  wire logic             i_bus_conv,
  input  wire mon_pkg::sample_t i_level,
  output mon_pkg::sample_t      o_sample
);
  import mon_pkg::*;
  // ========================================================================
  // Outside its conversion a result is not valid, so show the inverse
  assign o_sample.shunt = i_shunt_conv ? i_level.shunt : ~i_level.shunt;
  assign o_sample.bus   = i_bus_conv ? i_level.bus : ~i_level.bus;
  assign o_sample.power = i_bus_conv ? i_level.power : ~i_level.power;
endmodule : front_end_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(act, exp, msg) \
  begin \
    n_compared++; \
    if ((act) !== (exp)) begin \
      n_mismatch++; \
      $display("unexpected at %0t: %s", $time, msg); \
    end \
  end
module tb_top;
  import mon_pkg::*;
  localparam int CPU = 2;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  reg_req_t    req = '0;
  sample_t     level = '0;
  sample_t     smp;
  sample_t     res;
  logic [15:0] rdata;
  logic [15:0] d;
  logic        shc;
  logic        bsc;
  logic        al_oe;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          k;
  logic [15:0] t_mask [9] = '{16'hc000, 16'hc000, 16'h2000, 16'h1000,
    16'h1000, 16'h0800, 16'h0800, 16'h8002, 16'h8002};
  logic [15:0] t_val [9] = '{16'h0200, 16'h0050, 16'h0200, 16'h0200,
    16'h0050, 16'h0200, 16'h0050, 16'h0200, 16'h0050};
  logic        t_oe [9] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0,
    1'b0, 1'b1};

  always #5 clk = ~clk;

  mon_ctrl #(.CYCLES_PER_US(CPU)) i_mon_ctrl (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_REG_REQ(req), .I_SAMPLE(smp),
    .O_RESULT(res), .O_REG_RDATA(rdata), .O_SHUNT_CONV(shc),
    .O_BUS_CONV(bsc), .O_ALERT_O(), .O_ALERT_OE(al_oe));
  front_end_model i_front_end_model (
    .i_shunt_conv(shc), .i_bus_conv(bsc), .i_level(level), .o_sample(smp));

  // ========================================================================
  // Tasks
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic access(input logic w, input logic [7:0] a,
                        input logic [15:0] v);
    @(negedge clk);
    req = '{wr: w, rd: !w, addr: a, wdata: v};
    @(negedge clk);
    req = '0;
    d = rdata;
  endtask : access

  task automatic rdc(input logic [7:0] a, input logic [15:0] e,
                     input string m);
    access(1'b0, a, 16'h0000);
    `CHK(d, e, m)
  endtask : rdc

  // Bounded wait for n ends of bus conversion
  task automatic wait_set(input int n);
    int j;
    repeat (n) begin
      j = 0;
      while (!bsc && j < 3000) begin
        @(negedge clk);
        j++;
      end
      while (bsc && j < 3000) begin
        @(negedge clk);
        j++;
      end
      if (j >= 3000) begin
        n_mismatch++;
        $display("unexpected at %0t: no conversion end", $time);
        conclude();
      end
    end
  endtask : wait_set

  // ========================================================================
  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    rdc(8'h00, 16'h0127, "config reset");
    rdc(8'h06, 16'h0000, "mask reset");
    rdc(8'h07, 16'h0000, "limit reset");
    access(1'b1, 8'h02, 16'h5555);
    rdc(8'h02, 16'h0000, "result read only");
    rdc(8'h05, 16'h0000, "unmapped read");
    access(1'b1, 8'h06, 16'hffff);
    rdc(8'h06, 16'hfc03, "mask writable bits");
    access(1'b1, 8'h07, 16'h0100);
    rdc(8'h07, 16'h0100, "limit write");
    access(1'b1, 8'h00, 16'h7007);
    rdc(8'h00, 16'h0007, "config write");
    $display("test registers done");
    for (int i = 0; i < 9; i++) begin
      level = '{t_val[i], t_val[i], t_val[i]};
      access(1'b1, 8'h06, t_mask[i]);
      wait_set(2);
      `CHK(al_oe, t_oe[i], "limit")
    end
    $display("test limit checks done");
    level = '{16'h0200, 16'h0200, 16'h0200};
    access(1'b1, 8'h06, 16'h8001);
    wait_set(1);
    `CHK(al_oe, 1'b1, "latched alert")
    level.shunt = 16'h0050;
    wait_set(1);
    `CHK(al_oe, 1'b1, "latch holds")
    rdc(8'h06, 16'h8019, "flag view");
    `CHK(al_oe, 1'b0, "read clears latch")
    level.shunt = 16'h0200;
    wait_set(1);
    `CHK(al_oe, 1'b1, "latch set again")
    access(1'b1, 8'h00, 16'h0007);
    @(negedge clk);
    `CHK(al_oe, 1'b0, "write clears latch")
    $display("test latch done");
    level = '{16'h0010, 16'h0010, 16'h0010};
    access(1'b1, 8'h06, 16'h0400);
    wait_set(1);
    `CHK(al_oe, 1'b1, "ready on alert")
    `CHK(res.bus, 16'h0010, "result")
    `CHK(res.shunt, 16'h0010, "shunt result")
    `CHK(res.power, 16'h0010, "power result")
    access(1'b1, 8'h00, 16'h0001);
    `CHK(al_oe, 1'b0, "write clears ready")
    wait_set(1);
    rdc(8'h06, 16'h0408, "ready flag");
    `CHK(al_oe, 1'b0, "read clears ready")
    repeat (700) @(negedge clk);
    `CHK(shc, 1'b0, "single shot idle")
    $display("test single shot done");
    level.bus = 16'h0123;
    access(1'b1, 8'h00, 16'h0201);
    wait_set(1);
    `CHK(res.bus, 16'h0010, "no early load")
    `CHK(al_oe, 1'b0, "no early ready")
    wait_set(3);
    `CHK(res.bus, 16'h0123, "averaged load")
    `CHK(al_oe, 1'b1, "ready after four")
    $display("test averaging done");
    access(1'b1, 8'h00, 16'h0000);
    `CHK(al_oe, 1'b1, "power-down keeps ready")
    repeat (700) @(negedge clk);
    `CHK(shc | bsc, 1'b0, "power-down quiet")
    access(1'b1, 8'h00, 16'h0007);
    for (k = 0; !shc && k < 1000; k++) @(negedge clk);
    `CHK(k >= 100 * CPU - 3 && k < 1000, 1'b1, "recovery")
    $display("test power-down done");
    conclude();
  end
endmodule : tb_top
